//--- sru_unit.sv
// Shift, rotate and single-bit manipulation datapath slice.
`timescale 1ns/1ps

module sru_unit
   import sru_pkg::*;
(
   // Clock and reset.
   input  wire logic     REF_CLK_I,
   input  wire logic     RST_N_I,
   // Request from the decoder.
   input  wire sru_req_t REQ_I,
   // Answer to register file, memory path and flags.
   output sru_ans_t      ANS_O
);

   ////////////////////////////////////////////////////////////////////////////
   // Operand framing.

   logic [4:0]  msb;
   logic [31:0] mask;
   logic [31:0] field;
   logic        top_bit;
   logic [2:0]  bit_no;
   logic        sel_bit;
   logic        inv_op;
   logic [7:0]  one_hot;

   // Size picks the top position and the field; upper bits stay put.
   always_comb begin
      if (REQ_I.size == SZ_BYTE) begin
         msb  = MSB_BYTE;
         mask = MASK_BYTE;
      end else if (REQ_I.size == SZ_WORD) begin
         msb  = MSB_WORD;
         mask = MASK_WORD;
      end else begin
         msb  = MSB_LONG;
         mask = MASK_LONG;
      end
      field   = REQ_I.operand & mask;
      top_bit = REQ_I.operand[msb];
   end

   // Bit number from the immediate or from the low three register bits.
   assign bit_no  = REQ_I.bit_from_reg ? REQ_I.bit_reg[BITNO_W-1:0]
                                       : REQ_I.bit_imm;
   assign sel_bit = REQ_I.operand[bit_no];

   // One decoder line per bit of the byte operand.
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_hot
         assign one_hot[g] = (bit_no == 3'(g));
      end
   endgenerate

   // Inverted forms accept only an immediate bit number.
   always_comb begin
      case (REQ_I.op)
         carry_and_notbit_op, carry_or_notbit_op, carry_xor_notbit_op,
         notbit_to_carry_op, notcarry_to_bit_op: inv_op = 1'b1;
         default:                                 inv_op = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result computation and answer register.

   sru_ans_t    ans;
   sru_ans_t    next_ans;
   logic [31:0] shifted;
   logic        fill;
   logic        left;
   logic        is_shift;

   // Each request is answered one clock later; no request gives zero.
   always_comb begin
      next_ans         = '0;
      next_ans.done    = REQ_I.valid;
      next_ans.data    = REQ_I.operand;
      next_ans.carry   = REQ_I.carry;
      next_ans.zero    = 1'b0;
      shifted          = DATA_RST;
      fill             = 1'b0;
      left             = 1'b0;
      is_shift         = 1'b0;
      // The vacated end is filled per operation.
      case (REQ_I.op)
         arith_shift_left_op, logic_shift_left_op: begin
            left     = 1'b1;
            is_shift = 1'b1;
         end
         arith_shift_right_op: begin
            fill     = top_bit;
            is_shift = 1'b1;
         end
         logic_shift_right_op: begin
            is_shift = 1'b1;
         end
         rotate_left_op: begin
            left     = 1'b1;
            fill     = top_bit;
            is_shift = 1'b1;
         end
         rotate_right_op: begin
            fill     = REQ_I.operand[0];
            is_shift = 1'b1;
         end
         rotate_left_via_carry_op: begin
            left     = 1'b1;
            fill     = REQ_I.carry;
            is_shift = 1'b1;
         end
         rotate_right_via_carry_op: begin
            fill     = REQ_I.carry;
            is_shift = 1'b1;
         end
         default: begin
            is_shift = 1'b0;
         end
      endcase
      if (left) begin
         shifted = ((field << 1) | {31'h0, fill}) & mask;
      end else begin
         shifted = (field >> 1) | ({31'h0, fill} << msb);
      end
      if (is_shift) begin
         // One position per request; the leaving bit goes to carry.
         next_ans.data     = (REQ_I.operand & ~mask) | shifted;
         next_ans.data_we  = REQ_I.valid;
         next_ans.carry    = left ? top_bit : REQ_I.operand[0];
         next_ans.carry_we = REQ_I.valid;
      end else if (inv_op && REQ_I.bit_from_reg) begin
         // A refused request changes nothing; the flag tells the decoder.
         next_ans.illegal  = REQ_I.valid;
      end else begin
         case (REQ_I.op)
            bit_set_op: begin
               next_ans.data[7:0] = REQ_I.operand[7:0] | one_hot;
               next_ans.data_we   = REQ_I.valid;
            end
            bit_clear_op: begin
               next_ans.data[7:0] = REQ_I.operand[7:0] & ~one_hot;
               next_ans.data_we   = REQ_I.valid;
            end
            bit_invert_op: begin
               next_ans.data[7:0] = REQ_I.operand[7:0] ^ one_hot;
               next_ans.data_we   = REQ_I.valid;
            end
            bit_test_op: begin
               next_ans.zero    = ~sel_bit;
               next_ans.zero_we = REQ_I.valid;
            end
            carry_and_bit_op: begin
               next_ans.carry    = REQ_I.carry & sel_bit;
               next_ans.carry_we = REQ_I.valid;
            end
            carry_and_notbit_op: begin
               next_ans.carry    = REQ_I.carry & ~sel_bit;
               next_ans.carry_we = REQ_I.valid;
            end
            carry_or_bit_op: begin
               next_ans.carry    = REQ_I.carry | sel_bit;
               next_ans.carry_we = REQ_I.valid;
            end
            carry_or_notbit_op: begin
               next_ans.carry    = REQ_I.carry | ~sel_bit;
               next_ans.carry_we = REQ_I.valid;
            end
            carry_xor_bit_op: begin
               next_ans.carry    = REQ_I.carry ^ sel_bit;
               next_ans.carry_we = REQ_I.valid;
            end
            carry_xor_notbit_op: begin
               next_ans.carry    = REQ_I.carry ^ ~sel_bit;
               next_ans.carry_we = REQ_I.valid;
            end
            bit_to_carry_op: begin
               next_ans.carry    = sel_bit;
               next_ans.carry_we = REQ_I.valid;
            end
            notbit_to_carry_op: begin
               next_ans.carry    = ~sel_bit;
               next_ans.carry_we = REQ_I.valid;
            end
            carry_to_bit_op: begin
               next_ans.data[7:0] = (REQ_I.operand[7:0] & ~one_hot)
                                  | (one_hot & {8{REQ_I.carry}});
               next_ans.data_we   = REQ_I.valid;
            end
            notcarry_to_bit_op: begin
               next_ans.data[7:0] = (REQ_I.operand[7:0] & ~one_hot)
                                  | (one_hot & {8{~REQ_I.carry}});
               next_ans.data_we   = REQ_I.valid;
            end
            default: begin
               next_ans.illegal = REQ_I.valid;
            end
         endcase
      end
      if (!REQ_I.valid) begin
         next_ans = '0;
      end
   end

   // Answer register; all outputs come from here.
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ans <= '0;
      end else begin
         ans <= next_ans;
      end
   end

   assign ANS_O = ans;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_req(sru_op_t o);
      REQ_I.valid && REQ_I.op == o;
   endsequence

   sequence s_req_byte(sru_op_t o);
      s_req(o) ##0 REQ_I.size == SZ_BYTE;
   endsequence

   property p_arith_shift_left_op_byte;
      s_req_byte(arith_shift_left_op) |=>
         ans.data[7:0] == {$past(REQ_I.operand[6:0]), 1'b0} &&
         ans.carry == $past(REQ_I.operand[7]) && ans.data_we;
   endproperty
   a_arith_shift_left_op_byte: assert property (p_arith_shift_left_op_byte)
      else $error("byte arithmetic left shift wrong");

   property p_arith_shift_right_op_long;
      s_req(arith_shift_right_op) ##0 REQ_I.size == SZ_LONG |=>
         ans.data == {$past(REQ_I.operand[31]), $past(REQ_I.operand[31:1])};
   endproperty
   a_arith_shift_right_op_long: assert property (p_arith_shift_right_op_long)
      else $error("arithmetic right shift lost the sign");

   property p_logic_shift_right_op_word_keep;
      s_req(logic_shift_right_op) ##0 REQ_I.size == SZ_WORD |=>
         ans.data[31:16] == $past(REQ_I.operand[31:16]) &&
         ans.data[15] == 1'b0 && ans.carry == $past(REQ_I.operand[0]);
   endproperty
   a_logic_shift_right_op_word_keep: assert property (p_logic_shift_right_op_word_keep)
      else $error("word logical right shift wrong");

   property p_rotate_right_op_byte;
      s_req_byte(rotate_right_op) |=>
         ans.data[7] == $past(REQ_I.operand[0]) &&
         ans.data[6:0] == $past(REQ_I.operand[7:1]);
   endproperty
   a_rotate_right_op_byte: assert property (p_rotate_right_op_byte)
      else $error("byte right rotate wrong");

   property p_rotate_left_via_carry_op_ring;
      s_req_byte(rotate_left_via_carry_op) |=>
         ans.data[0] == $past(REQ_I.carry) &&
         ans.carry == $past(REQ_I.operand[7]) && ans.carry_we;
   endproperty
   a_rotate_left_via_carry_op_ring: assert property (p_rotate_left_via_carry_op_ring)
      else $error("carry not in the rotate ring");

   property p_bit_set_op;
      s_req(bit_set_op) ##0 !REQ_I.bit_from_reg |=>
         ans.data[$past(REQ_I.bit_imm)] == 1'b1 && ans.data_we;
   endproperty
   a_bit_set_op: assert property (p_bit_set_op)
      else $error("bit set did not set the bit");

   property p_bit_clear_op_reg;
      s_req(bit_clear_op) ##0 REQ_I.bit_from_reg |=>
         ans.data[$past(REQ_I.bit_reg[2:0])] == 1'b0;
   endproperty
   a_bit_clear_op_reg: assert property (p_bit_clear_op_reg)
      else $error("bit clear by register number wrong");

   property p_bit_invert_op;
      s_req(bit_invert_op) ##0 !REQ_I.bit_from_reg |=>
         ans.data[$past(REQ_I.bit_imm)] !=
         $past(REQ_I.operand[REQ_I.bit_imm]);
   endproperty
   a_bit_invert_op: assert property (p_bit_invert_op)
      else $error("bit invert did not invert");

   property p_bit_test_op;
      s_req(bit_test_op) |=> ans.zero_we && !ans.data_we &&
         ans.zero == !$past(sel_bit);
   endproperty
   a_bit_test_op: assert property (p_bit_test_op)
      else $error("bit test zero flag wrong");

   property p_band;
      s_req(carry_and_bit_op) |=>
         ans.carry == ($past(REQ_I.carry) && $past(sel_bit));
   endproperty
   a_band: assert property (p_band)
      else $error("carry AND bit wrong");

   property p_inv_reg_refused;
      REQ_I.valid && inv_op && REQ_I.bit_from_reg |=>
         ans.illegal && !ans.carry_we && !ans.data_we;
   endproperty
   a_inv_reg_refused: assert property (p_inv_reg_refused)
      else $error("inverted form took a register bit number");

   property p_bst;
      s_req(carry_to_bit_op) ##0 !REQ_I.bit_from_reg |=>
         ans.data[$past(REQ_I.bit_imm)] == $past(REQ_I.carry);
   endproperty
   a_bst: assert property (p_bst)
      else $error("bit store did not write carry");

endmodule // sru_unit

//--- sru_pkg.sv
// Package with the types and constants of the shift, rotate and bit unit.
package sru_pkg;

   // Operand width and bit number width.
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned BITNO_W = 3;

   // Top bit positions of each operand size.
   localparam logic [4:0] MSB_BYTE = 5'h07;
   localparam logic [4:0] MSB_WORD = 5'h0F;
   localparam logic [4:0] MSB_LONG = 5'h1F;

   // Field masks of each operand size.
   localparam logic [31:0] MASK_BYTE = 32'h0000_00FF;
   localparam logic [31:0] MASK_WORD = 32'h0000_FFFF;
   localparam logic [31:0] MASK_LONG = 32'hFFFF_FFFF;

   // Default of the shifted result; the answer register itself resets to zero.
   localparam logic [31:0] DATA_RST = 32'h0000_0000;

   // Operand size.
   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_WORD = 2'b01,
      SZ_LONG = 2'b10
   } sru_size_t;

   // Operation codes.
   typedef enum logic [4:0] {
      arith_shift_left_op       = 5'b00000,
      arith_shift_right_op      = 5'b00001,
      logic_shift_left_op       = 5'b00010,
      logic_shift_right_op      = 5'b00011,
      rotate_left_op            = 5'b00100,
      rotate_right_op           = 5'b00101,
      rotate_left_via_carry_op  = 5'b00110,
      rotate_right_via_carry_op = 5'b00111,
      bit_set_op                = 5'b01000,
      bit_clear_op              = 5'b01001,
      bit_invert_op             = 5'b01010,
      bit_test_op               = 5'b01011,
      carry_and_bit_op          = 5'b01100,
      carry_and_notbit_op       = 5'b01101,
      carry_or_bit_op           = 5'b01110,
      carry_or_notbit_op        = 5'b01111,
      carry_xor_bit_op          = 5'b10000,
      carry_xor_notbit_op       = 5'b10001,
      bit_to_carry_op           = 5'b10010,
      notbit_to_carry_op        = 5'b10011,
      carry_to_bit_op           = 5'b10100,
      notcarry_to_bit_op        = 5'b10101
   } sru_op_t;

   // Request from the decoder with operand and current carry.
   typedef struct packed {
      logic              valid;
      sru_op_t           op;
      sru_size_t         size;
      logic              bit_from_reg;
      logic [2:0]        bit_imm;
      logic [7:0]        bit_reg;
      logic [31:0]       operand;
      logic              carry;
   } sru_req_t;

   // Answer to the register file, memory path and flags.
   typedef struct packed {
      logic              done;
      logic              illegal;
      logic [31:0]       data;
      logic              data_we;
      logic              carry;
      logic              carry_we;
      logic              zero;
      logic              zero_we;
   } sru_ans_t;

endpackage

//--- sru_dec_model.sv
// Decoder and register file model that feeds requests to the unit.
`timescale 1ns/1ps

module sru_dec_model
   import sru_pkg::*;
(
   // Clock.
   input  wire logic REF_CLK_I,
   // Request toward the unit.
   output sru_req_t  REQ_O
);

   sru_req_t req;

   assign REQ_O = req;

   // Nothing is offered before the first falling edge.
   initial begin
      req = '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Presents one request at the falling edge; the caller lets one rising
   // edge take it, so back-to-back requests need no gap.
   task automatic send(input sru_req_t r);
      sru_req_t t;
      t = r;
      t.valid = 1'b1;
      @(negedge REF_CLK_I);
      req = t;
   endtask

   // Withdraws the request; stale fields are inverted so that an answer
   // built from old data cannot pass by luck.
   task automatic idle();
      sru_req_t t;
      @(negedge REF_CLK_I);
      t = req;
      t.valid = 1'b0;
      t.operand = ~t.operand;
      t.carry = ~t.carry;
      t.bit_imm = ~t.bit_imm;
      t.bit_reg = ~t.bit_reg;
      req = t;
   endtask

endmodule // sru_dec_model

//--- testbench.sv
// Self-checking testbench of the shift, rotate and bit unit.
`timescale 1ns/1ps

`define CHK(nm, e, g) begin \
   comparisons++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
   end \
end

module testbench
   import sru_pkg::*;
;

   logic     ref_clk;
   logic     rst_n;
   sru_req_t req;
   sru_ans_t ans;
   int       n_errors;
   int       comparisons;
   int       cycles;

   // Answer with every field at zero, seen in reset and between requests.
   localparam sru_ans_t ANS_IDLE = '0;

   sru_dec_model i_dec (.REF_CLK_I(ref_clk), .REQ_O(req));

   sru_unit i_dut (.REF_CLK_I(ref_clk), .RST_N_I(rst_n), .REQ_I(req),
                   .ANS_O(ans));

   ////////////////////////////////////////////////////////////////////////////
   // Clock of 20 ns and a hang guard; the ceiling is far above the run.
   initial begin
      ref_clk = 1'b0;
   end
   always #10 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         end_sim();
      end
   end

   // Verdict and end of run.
   task automatic end_sim();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Reference answer; bits outside the size and above bit 7 pass through.
   function automatic sru_ans_t expect_ans(sru_req_t r);
      sru_ans_t    a;
      logic [31:0] m;
      logic [31:0] f;
      logic [31:0] s;
      logic [4:0]  t;
      logic [2:0]  n;
      logic        b;
      logic        inv;
      a = '0;
      a.done = 1'b1;
      a.data = r.operand;
      a.carry = r.carry;
      t = (r.size == SZ_BYTE) ? MSB_BYTE
        : (r.size == SZ_WORD) ? MSB_WORD : MSB_LONG;
      m = (r.size == SZ_BYTE) ? MASK_BYTE
        : (r.size == SZ_WORD) ? MASK_WORD : MASK_LONG;
      f = r.operand & m;
      n = r.bit_from_reg ? r.bit_reg[2:0] : r.bit_imm;
      b = r.operand[n];
      inv = r.op inside {carry_and_notbit_op, carry_or_notbit_op,
                         carry_xor_notbit_op, notbit_to_carry_op,
                         notcarry_to_bit_op};
      if ((inv && r.bit_from_reg) || r.op > notcarry_to_bit_op) begin
         a.illegal = 1'b1;
      end else if (r.op <= rotate_right_via_carry_op) begin
         a.data_we = 1'b1;
         a.carry_we = 1'b1;
         if (r.op[0] == 1'b0) begin
            a.carry = f[t];
            s = {f[30:0], (r.op == rotate_left_op) ? f[t]
                 : (r.op == rotate_left_via_carry_op) ? r.carry : 1'b0};
         end else begin
            a.carry = f[0];
            s = f >> 1;
            s[t] = (r.op == arith_shift_right_op) ? f[t]
                 : (r.op == rotate_right_op) ? f[0]
                 : (r.op == rotate_right_via_carry_op) ? r.carry : 1'b0;
         end
         a.data = (r.operand & ~m) | (s & m);
      end else begin
         a.data_we = r.op inside {bit_set_op, bit_clear_op, bit_invert_op,
                                  carry_to_bit_op, notcarry_to_bit_op};
         a.zero_we = (r.op == bit_test_op);
         a.carry_we = !a.data_we && !a.zero_we;
         a.zero = !b;
         case (r.op)
            bit_set_op:          a.data[n] = 1'b1;
            bit_clear_op:        a.data[n] = 1'b0;
            bit_invert_op:       a.data[n] = !b;
            carry_to_bit_op:     a.data[n] = r.carry;
            notcarry_to_bit_op:  a.data[n] = !r.carry;
            carry_and_bit_op:    a.carry = r.carry & b;
            carry_and_notbit_op: a.carry = r.carry & !b;
            carry_or_bit_op:     a.carry = r.carry | b;
            carry_or_notbit_op:  a.carry = r.carry | !b;
            carry_xor_bit_op:    a.carry = r.carry ^ b;
            carry_xor_notbit_op: a.carry = r.carry ^ !b;
            bit_to_carry_op:     a.carry = b;
            notbit_to_carry_op:  a.carry = !b;
            default:             a.carry = r.carry;
         endcase
      end
      return a;
   endfunction

   // Sends one request and judges the answer after the taking edge.
   task automatic run_one(input sru_req_t r);
      sru_ans_t e;
      sru_ans_t g;
      e = expect_ans(r);
      i_dec.send(r);
      @(posedge ref_clk);
      #1;
      g = ans;
      if (e.zero_we === 1'b0) begin
         g.zero = e.zero;
      end
      `CHK("answer", e, g)
   endtask

   // After an idle cycle every answer field is back to zero.
   task automatic check_idle();
      i_dec.idle();
      @(posedge ref_clk);
      #1;
      `CHK("idle answer", ANS_IDLE, ans)
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Every shift and rotate, every size, both carries, back to back.
   task automatic t_shift();
      sru_req_t r;
      for (int k = 0; k < 8; k++) begin
         for (int s = 0; s < 3; s++) begin
            for (int p = 0; p < 4; p++) begin
               r = '0;
               r.op = sru_op_t'(k[4:0]);
               r.size = sru_size_t'(s[1:0]);
               r.operand = p[1] ? 32'h4000_7F7E : 32'hC000_8081;
               r.carry = p[0];
               run_one(r);
            end
         end
      end
      check_idle();
   endtask

   // Every bit operation on every bit number from both number sources;
   // inverted operations with a register number must be refused.
   task automatic t_bit();
      sru_req_t r;
      for (int k = 8; k < 22; k++) begin
         for (int fr = 0; fr < 2; fr++) begin
            for (int n = 0; n < 8; n++) begin
               r = '0;
               r.op = sru_op_t'(k[4:0]);
               r.bit_from_reg = fr[0];
               r.bit_imm = fr[0] ? ~n[2:0] : n[2:0];
               r.bit_reg = fr[0] ? {5'h15, n[2:0]} : {5'h0A, ~n[2:0]};
               r.operand = {24'hA5C396, 8'h5A ^ 8'(n * 19) ^ 8'(k)};
               r.carry = n[0] ^ fr[0];
               run_one(r);
            end
         end
      end
      check_idle();
   endtask

   // Undefined codes are answered as illegal with no writes.
   task automatic t_refused();
      sru_req_t r;
      for (int k = 22; k < 32; k++) begin
         r = '0;
         r.op = sru_op_t'(k[4:0]);
         r.operand = 32'h1234_5678;
         r.carry = k[0];
         run_one(r);
      end
      check_idle();
   endtask

   // Reset in mid-run clears the answer at once, with a request pending.
   task automatic t_reset();
      sru_req_t r;
      r = '0;
      r.op = bit_set_op;
      r.operand = 32'h0000_00F0;
      i_dec.send(r);
      @(negedge ref_clk);
      rst_n = 1'b0;
      #1;
      `CHK("reset answer", ANS_IDLE, ans)
      i_dec.idle();
      rst_n = 1'b1;
      r.op = carry_to_bit_op;
      r.carry = 1'b1;
      run_one(r);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset for four cycles, then every scenario.
   initial begin
      rst_n = 1'b0;
      n_errors = 0;
      comparisons = 0;
      cycles = 0;
      repeat (4) @(negedge ref_clk);
      `CHK("reset answer", ANS_IDLE, ans)
      rst_n = 1'b1;
      t_shift();
      t_bit();
      t_refused();
      t_reset();
      end_sim();
   end

endmodule // testbench
